// *** swel_top.sv ***
// always-on sleep entry, wake-up event collection and retained state
//
// What this block does
// - supply delta sets flag; wakes when enabled
// - supply restore always wakes, sets rail bit
// - midnight tick always wakes the core
// - pin A wakes on selected edge, pending untouched
// - pin B wakes on selected edge, field 11x
// - rx edge wakes when field 11, sets flag
// - reset pin low in sleep always wakes
// - display switchable in sleep, memory retained
// - four scratch registers survive sleep
// - pins become inputs in sleep, pull-ups kept
// - wake restarts core at reset vector
//
// The address-and-strobe port is this design's own decision.
module swel_top
  import swel_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic temp_delta_in,
  input wire logic supply_delta_in,
  input wire logic supply_restored_event_in,
  input wire logic battery_switch_in,
  input wire logic midnight_in,
  input wire logic alarm_in,
  input wire logic ext_irq_a_pin_in,
  input wire logic ext_irq_b_pin_in,
  input wire logic rx_line_in,
  input wire logic ext_reset_n_in,
  input wire logic [23:0] core_io_oe_in,
  output logic [23:0] io_oe_out,
  output logic [23:0] pullup_en_out,
  output logic lcd_on_out,
  output logic core_run_out,
  output logic core_restart_out,
  output logic sleep_state_out,
  output logic power_mgmt_irq_out,
  output logic irq_out
);
  swel_mem_if mem_bus ();

  swel_mem u_mem (
    .clk_in(clk_in),
    .bus(mem_bus.mem)
  );

  // selected edge: sel high means falling, low means rising
  function automatic logic edge_hit(input logic prev, input logic cur, input logic sel);
    edge_hit = sel ? (prev & ~cur) : (~prev & cur);
  endfunction : edge_hit

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic st);
    hit = st && (a == target);
  endfunction : hit

  // control and retained registers share one reset; sleep never touches them
  swel_state_t state_reg, state_next;
  logic [7:0] ext_ctrl_reg, ext_ctrl_next;
  logic [7:0] rtc_cfg_reg, rtc_cfg_next;
  logic [7:0] pwr_irq_en_reg, pwr_irq_en_next;
  logic [7:0] delta_cfg_reg, delta_cfg_next;
  logic [7:0] peripheral_configuration_reg, peripheral_configuration_next;
  logic [7:0] wake_pins_reg, wake_pins_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] lcd_ptr_reg, lcd_ptr_next;
  logic [7:0] pullup_reg [PORT_NUM];
  logic [7:0] pullup_next [PORT_NUM];
  logic [7:0] scratch_reg [SCRATCH_NUM];
  logic [7:0] scratch_next [SCRATCH_NUM];
  logic [7:0] rdata_reg, rdata_next;
  logic mem_sel_reg, mem_sel_next;
  logic wake_req_reg, wake_req_next;
  logic ext_a_prev_reg, ext_b_prev_reg, rx_prev_reg;
  logic [7:0] events;
  logic ext_a_edge, ext_b_edge, rx_edge;
  logic sleeping;
  logic wake_any;

  // one decoded view of the state, shared by event gates and pin control
  assign sleeping = (state_reg == SWEL_SLEEP);

  // pin edge detection, inputs already synchronous to clk_in
  assign ext_a_edge = edge_hit(ext_a_prev_reg, ext_irq_a_pin_in, ext_ctrl_reg[EXT_A_EDGE_BIT]);
  assign ext_b_edge = edge_hit(ext_b_prev_reg, ext_irq_b_pin_in, ext_ctrl_reg[EXT_B_EDGE_BIT]);
  assign rx_edge = rx_prev_reg ^ rx_line_in; // either direction

  // raw events, each one latched as a sticky status bit
  always_comb begin
    events = 8'h00;
    events[WS_TEMP] = temp_delta_in && delta_cfg_reg[TEMP_MEAS_EN_BIT];
    events[WS_SUPPLY_DELTA] = supply_delta_in;
    events[WS_SUPPLY_RESTORED] = supply_restored_event_in;
    events[WS_MIDNIGHT] = midnight_in;
    events[WS_ALARM] = alarm_in && rtc_cfg_reg[ALARM_EN_BIT];
    // pin and rx sources only count while asleep; awake edges belong to the core
    events[WS_EXT_A] = sleeping && ext_a_edge
      && (wake_pins_reg[EXT_A_FIELD_BIT] == EXT_A_WAKE_CODE);
    events[WS_EXT_B] = sleeping && ext_b_edge
      && (wake_pins_reg[EXT_B_FIELD_LSB+1 +: 2] == EXT_B_WAKE_CODE);
    events[WS_RX_EDGE] = sleeping && rx_edge
      && (peripheral_configuration_reg[RX_FIELD_LSB +: 2] == RX_WAKE_CODE);
  end

  // combined wake: nonmaskable sources plus enabled maskable ones
  always_comb begin
    wake_any = status_reg[WS_SUPPLY_RESTORED] || status_reg[WS_MIDNIGHT];
    // temperature and alarm are already gated where their events are formed
    wake_any = wake_any || status_reg[WS_TEMP] || status_reg[WS_ALARM];
    wake_any = wake_any || (status_reg[WS_SUPPLY_DELTA]
      && pwr_irq_en_reg[SUPPLY_DELTA_EN_BIT]);
    wake_any = wake_any || status_reg[WS_EXT_A] || status_reg[WS_EXT_B];
    wake_any = wake_any || status_reg[WS_RX_EDGE];
    // a flag left set before sleeping wakes at once, so firmware must clear it
    wake_any = wake_any || !ext_reset_n_in;
    // registering the request costs a cycle but keeps pin glitches off the state
    wake_req_next = sleeping && wake_any;
  end

  // register writes and status updates; a new event beats a clear
  always_comb begin
    ext_ctrl_next = ext_ctrl_reg;
    rtc_cfg_next = rtc_cfg_reg;
    pwr_irq_en_next = pwr_irq_en_reg;
    delta_cfg_next = delta_cfg_reg;
    peripheral_configuration_next = peripheral_configuration_reg;
    wake_pins_next = wake_pins_reg;
    status_next = status_reg;
    mask_next = mask_reg;
    lcd_ptr_next = lcd_ptr_reg;
    pullup_next = pullup_reg;
    scratch_next = scratch_reg;
    if (hit(addr_in, ADDR_EXT_TIMER_CTRL, wr_in)) begin
      ext_ctrl_next = wdata_in;
    end
    if (hit(addr_in, ADDR_RTC_CONFIG, wr_in)) begin
      rtc_cfg_next = wdata_in;
    end
    if (hit(addr_in, ADDR_POWER_IRQ_EN, wr_in)) begin
      pwr_irq_en_next = wdata_in;
    end
    if (hit(addr_in, ADDR_DELTA_CONFIG, wr_in)) begin
      delta_cfg_next = wdata_in;
    end
    if (hit(addr_in, ADDR_WAKE_PINS, wr_in)) begin
      wake_pins_next = wdata_in;
    end
    if (hit(addr_in, ADDR_WAKE_MASK, wr_in)) begin
      mask_next = wdata_in;
    end
    if (hit(addr_in, ADDR_LCD_PTR, wr_in)) begin
      lcd_ptr_next = wdata_in;
    end
    // rail source bit is read-only, rx edge flag is write-one-to-clear
    if (hit(addr_in, ADDR_PERIPHERAL_CONFIGURATION_CONFIG, wr_in)) begin
      peripheral_configuration_next[5:0] = wdata_in[5:0];
      if (wdata_in[RX_EDGE_FLAG_BIT]) begin
        peripheral_configuration_next[RX_EDGE_FLAG_BIT] = 1'b0;
      end
    end
    if (hit(addr_in, ADDR_WAKE_STATUS, wr_in)) begin
      status_next = status_reg & ~wdata_in;
    end
    // pull-up and scratch banks decode as runs of adjacent offsets
    for (int p = 0; p < PORT_NUM; p++) begin
      if (hit(addr_in, ADDR_PORT0_PULLUP + 8'(p), wr_in)) begin
        pullup_next[p] = wdata_in;
      end
    end
    for (int s = 0; s < SCRATCH_NUM; s++) begin
      if (hit(addr_in, ADDR_SCRATCH_BASE + 8'(s), wr_in)) begin
        scratch_next[s] = wdata_in;
      end
    end
    // standard pending flags only follow the pins while awake
    if (!sleeping && ext_a_edge) begin
      ext_ctrl_next[EXT_A_PEND_BIT] = 1'b1;
    end
    if (!sleeping && ext_b_edge) begin
      ext_ctrl_next[EXT_B_PEND_BIT] = 1'b1;
    end
    // events merge after the write, so a same-cycle clear never loses one
    status_next = status_next | events;
    if (events[WS_RX_EDGE]) begin
      peripheral_configuration_next[RX_EDGE_FLAG_BIT] = 1'b1;
    end
    // battery switch clears the rail bit; a coincident restore still wins
    if (battery_switch_in) begin
      peripheral_configuration_next[RAIL_SOURCE_BIT] = 1'b0;
    end
    if (supply_restored_event_in) begin
      peripheral_configuration_next[RAIL_SOURCE_BIT] = 1'b1;
    end
  end

  // power state: sleep on firmware request, restart through the reset vector
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWEL_AWAKE: begin
        if (hit(addr_in, ADDR_POWER_CTRL, wr_in) && wdata_in[SLEEP_ENTER_BIT]) begin
          state_next = SWEL_SLEEP;
        end
      end
      SWEL_SLEEP: begin
        if (wake_req_reg) begin
          state_next = SWEL_WAKING;
        end
      end
      // one restart cycle, so the core always leaves through its reset vector
      SWEL_WAKING: begin
        state_next = SWEL_AWAKE;
      end
      default: begin
        state_next = SWEL_AWAKE;
      end
    endcase
  end

  // read path: one cycle after the strobe, unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    // display reads come from the memory's own register, selected a cycle late
    mem_sel_next = hit(addr_in, ADDR_LCD_DATA, rd_in);
    if (rd_in) begin
      case (addr_in)
        ADDR_EXT_TIMER_CTRL: rdata_next = ext_ctrl_reg;
        ADDR_RTC_CONFIG: rdata_next = rtc_cfg_reg;
        ADDR_LCD_PTR: rdata_next = lcd_ptr_reg;
        ADDR_PORT0_PULLUP: rdata_next = pullup_reg[0];
        ADDR_PORT1_PULLUP: rdata_next = pullup_reg[1];
        ADDR_PORT2_PULLUP: rdata_next = pullup_reg[2];
        ADDR_POWER_CTRL: rdata_next = 8'h00;
        ADDR_WAKE_STATUS: rdata_next = status_reg;
        ADDR_WAKE_MASK: rdata_next = mask_reg;
        ADDR_POWER_IRQ_EN: rdata_next = pwr_irq_en_reg;
        ADDR_DELTA_CONFIG: rdata_next = delta_cfg_reg;
        ADDR_PERIPHERAL_CONFIGURATION_CONFIG: rdata_next = peripheral_configuration_reg;
        ADDR_WAKE_PINS: rdata_next = wake_pins_reg;
        default: begin
          for (int s = 0; s < SCRATCH_NUM; s++) begin
            if (addr_in == ADDR_SCRATCH_BASE + 8'(s)) begin
              rdata_next = scratch_reg[s];
            end
          end
        end
      endcase
    end
  end

  // display memory: written and read at the pointer, never cleared
  assign mem_bus.we = hit(addr_in, ADDR_LCD_DATA, wr_in);
  assign mem_bus.addr = lcd_ptr_reg[LCD_AW-1:0];
  assign mem_bus.wdata = wdata_in;

  // single reset: scratch and config are not touched by sleep, only by nrst_in
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= SWEL_AWAKE;
      ext_ctrl_reg <= REG_RESET;
      rtc_cfg_reg <= REG_RESET;
      pwr_irq_en_reg <= REG_RESET;
      delta_cfg_reg <= REG_RESET;
      peripheral_configuration_reg <= REG_RESET;
      wake_pins_reg <= REG_RESET;
      status_reg <= REG_RESET;
      mask_reg <= REG_RESET;
      lcd_ptr_reg <= REG_RESET;
      rdata_reg <= REG_RESET;
      mem_sel_reg <= 1'b0;
      wake_req_reg <= 1'b0;
      ext_a_prev_reg <= 1'b0;
      ext_b_prev_reg <= 1'b0;
      // receive line idles high; a low reset value would fake an edge
      rx_prev_reg <= 1'b1;
      for (int p = 0; p < PORT_NUM; p++) begin
        pullup_reg[p] <= PULLUP_RESET;
      end
      for (int s = 0; s < SCRATCH_NUM; s++) begin
        scratch_reg[s] <= REG_RESET;
      end
    end else begin
      state_reg <= state_next;
      ext_ctrl_reg <= ext_ctrl_next;
      rtc_cfg_reg <= rtc_cfg_next;
      pwr_irq_en_reg <= pwr_irq_en_next;
      delta_cfg_reg <= delta_cfg_next;
      peripheral_configuration_reg <= peripheral_configuration_next;
      wake_pins_reg <= wake_pins_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      lcd_ptr_reg <= lcd_ptr_next;
      rdata_reg <= rdata_next;
      mem_sel_reg <= mem_sel_next;
      wake_req_reg <= wake_req_next;
      ext_a_prev_reg <= ext_irq_a_pin_in;
      ext_b_prev_reg <= ext_irq_b_pin_in;
      rx_prev_reg <= rx_line_in;
      pullup_reg <= pullup_next;
      scratch_reg <= scratch_next;
    end
  end

  // pin control: sleep forces every pin to input, pull-ups stay as set
  genvar g;
  generate
    for (g = 0; g < PORT_NUM; g++) begin : g_port
      assign pullup_en_out[g*8 +: 8] = pullup_reg[g];
      assign io_oe_out[g*8 +: 8] = sleeping ? 8'h00 : core_io_oe_in[g*8 +: 8];
    end
  endgenerate

  assign rdata_out = mem_sel_reg ? mem_bus.rdata : rdata_reg;
  assign lcd_on_out = !sleeping || peripheral_configuration_reg[LCD_SLEEP_EN_BIT];
  assign core_run_out = (state_reg == SWEL_AWAKE);
  assign core_restart_out = (state_reg == SWEL_WAKING);
  assign sleep_state_out = sleeping;
  // power irq: gated supply delta or an unconditional restore
  assign power_mgmt_irq_out = (status_reg[WS_SUPPLY_DELTA] && pwr_irq_en_reg[SUPPLY_DELTA_EN_BIT])
    || status_reg[WS_SUPPLY_RESTORED];
  // the mask only gates this line, never the wake request
  assign irq_out = |(status_reg & mask_reg);
endmodule : swel_top

// *** swel_pkg.sv ***
// shared register map, field positions and state codes of the sleep wake-up logic
package swel_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] ADDR_EXT_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_RTC_CONFIG = 8'ha1;
  localparam logic [7:0] ADDR_LCD_PTR = 8'hac;
  localparam logic [7:0] ADDR_LCD_DATA = 8'hae;
  localparam logic [7:0] ADDR_PORT0_PULLUP = 8'hb2;
  localparam logic [7:0] ADDR_PORT1_PULLUP = 8'hb3;
  localparam logic [7:0] ADDR_PORT2_PULLUP = 8'hb4;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'hc5;
  localparam logic [7:0] ADDR_WAKE_STATUS = 8'hd8;
  localparam logic [7:0] ADDR_WAKE_MASK = 8'hd9;
  localparam logic [7:0] ADDR_POWER_IRQ_EN = 8'hec;
  localparam logic [7:0] ADDR_DELTA_CONFIG = 8'hf3;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIGURATION_CONFIG = 8'hf4;
  localparam logic [7:0] ADDR_SCRATCH_BASE = 8'hfb;
  localparam logic [7:0] ADDR_WAKE_PINS = 8'hff;

  // field positions
  localparam int EXT_A_EDGE_BIT = 0;
  localparam int EXT_A_PEND_BIT = 1;
  localparam int EXT_B_EDGE_BIT = 2;
  localparam int EXT_B_PEND_BIT = 3;
  localparam int ALARM_EN_BIT = 1;
  localparam int SLEEP_ENTER_BIT = 4;
  localparam int SUPPLY_DELTA_EN_BIT = 2;
  localparam int TEMP_MEAS_EN_BIT = 3;
  localparam int RX_EDGE_FLAG_BIT = 7;
  localparam int RAIL_SOURCE_BIT = 6;
  localparam int LCD_SLEEP_EN_BIT = 5;
  localparam int RX_FIELD_LSB = 0;
  localparam int EXT_A_FIELD_BIT = 0;
  localparam int EXT_B_FIELD_LSB = 1;

  // wake status bit order, shared by status and mask registers
  localparam int WS_TEMP = 0;
  localparam int WS_SUPPLY_DELTA = 1;
  localparam int WS_SUPPLY_RESTORED = 2;
  localparam int WS_MIDNIGHT = 3;
  localparam int WS_ALARM = 4;
  localparam int WS_EXT_A = 5;
  localparam int WS_EXT_B = 6;
  localparam int WS_RX_EDGE = 7;

  // wake field codes
  localparam logic EXT_A_WAKE_CODE = 1'b1;
  localparam logic [1:0] EXT_B_WAKE_CODE = 2'b11;
  localparam logic [1:0] RX_WAKE_CODE = 2'b11;

  // sizes and reset values
  localparam int SCRATCH_NUM = 4;
  localparam int LCD_DEPTH = 16;
  localparam int LCD_AW = 4;
  localparam int PORT_NUM = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'hff;

  typedef enum logic [1:0] {
    SWEL_AWAKE = 2'b00,
    SWEL_SLEEP = 2'b01,
    SWEL_WAKING = 2'b10
  } swel_state_t;
endpackage : swel_pkg

// *** swel_mem_if.sv ***
// carrier between the control logic and the retained display memory
interface swel_mem_if;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : swel_mem_if

// *** swel_mem.sv ***
// retained display data memory with registered read data
module swel_mem
  import swel_pkg::*;
(
  input wire logic clk_in,
  swel_mem_if.mem bus
);
  // no reset on the array: contents survive sleep and core restarts
  logic [7:0] store [LCD_DEPTH];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_in) begin
    if (bus.we) begin
      store[bus.addr] <= bus.wdata;
    end
    rdata_reg <= store[bus.addr];
  end

  assign bus.rdata = rdata_reg;
endmodule : swel_mem

// *** swel_checker.sv ***
// port-level assertions on sleep entry, wake timing and pin state
module swel_checker
  import swel_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic midnight_in,
  input wire logic supply_restored_event_in,
  input wire logic ext_reset_n_in,
  input wire logic [23:0] core_io_oe_in,
  input wire logic [23:0] io_oe_out,
  input wire logic [23:0] pullup_en_out,
  input wire logic core_run_out,
  input wire logic core_restart_out,
  input wire logic sleep_state_out,
  input wire logic power_mgmt_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic go_sleep;
  // sleep request as decoded from a control write
  assign go_sleep = wr_in && addr_in == ADDR_POWER_CTRL && wdata_in[SLEEP_ENTER_BIT];
  chk_sleep_entry: assert property (
    core_run_out && go_sleep |=> sleep_state_out && !core_run_out)
    else $error("sleep not entered");
  chk_io_inputs: assert property (
    sleep_state_out |-> io_oe_out == 24'h00_0000) else $error("pin driven in sleep");
  chk_io_awake: assert property (
    core_run_out |-> io_oe_out == core_io_oe_in) else $error("awake enables lost");
  chk_pullup_reset: assert property (
    $rose(nrst_in) |-> pullup_en_out == 24'hff_ffff) else $error("pullup reset wrong");
  chk_midnight_wake: assert property (
    sleep_state_out && midnight_in |-> ##3 core_restart_out ##1 core_run_out)
    else $error("midnight wake late");
  chk_restore_wake: assert property (
    sleep_state_out && supply_restored_event_in |-> ##3 core_restart_out ##1 core_run_out)
    else $error("restore wake late");
  chk_reset_wake: assert property (
    sleep_state_out && !ext_reset_n_in |-> ##[1:3] core_restart_out)
    else $error("reset pin wake missing");
  chk_restart_once: assert property (
    core_restart_out |=> !core_restart_out && core_run_out) else $error("restart not a pulse");
  chk_restart_cause: assert property (
    core_restart_out |-> $past(sleep_state_out)) else $error("restart without sleep");
  chk_restore_irq: assert property (
    supply_restored_event_in |=> power_mgmt_irq_out) else $error("restore irq missing");
  // main wake paths seen at least once
  cover property (sleep_state_out && midnight_in);
  cover property (sleep_state_out && !ext_reset_n_in);
  cover property (core_restart_out);
endmodule : swel_checker

bind swel_top swel_checker u_swel_checker (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in,
  .midnight_in, .supply_restored_event_in, .ext_reset_n_in, .core_io_oe_in, .io_oe_out,
  .pullup_en_out, .core_run_out, .core_restart_out, .sleep_state_out, .power_mgmt_irq_out);

// *** swel_src.sv ***
// wake source model: one-cycle event pulses and single pin edges
module swel_src (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [3:0] sel_in,
  output logic [5:0] ev_out,
  output logic pin_a_out,
  output logic pin_b_out,
  output logic rx_out,
  output logic rst_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // uart line idles high, reset pin is pulled up
  initial begin
    ev_out = 6'h00;
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
    rx_out = 1'b1;
    rst_n_out = 1'b1;
  end
  // a toggle gives exactly one edge per command, never a glitch pair
  always @(posedge clk_in) begin
    ev_out <= (go_in && sel_in < 4'h6) ? 6'h01 << sel_in : 6'h00;
    if (go_in && sel_in == 4'h6) pin_a_out <= ~pin_a_out;
    if (go_in && sel_in == 4'h7) pin_b_out <= ~pin_b_out;
    if (go_in && sel_in == 4'h8) rx_out <= ~rx_out;
    rst_n_out <= !(go_in && sel_in == 4'h9);
  end
endmodule : swel_src

// *** tb.sv ***
// self-checking bench for the sleep wake-up logic
module tb
  import swel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic go = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [23:0] core_io_oe_in = 24'h00_0000;
  logic [5:0] ev;
  logic pin_a, pin_b, rx, rst_n, lcd_on_out, core_run_out, core_restart_out;
  logic sleep_state_out, power_mgmt_irq_out, irq_out;
  logic [7:0] rdata_out;
  logic [23:0] io_oe_out, pullup_en_out;
  logic [7:0] q[$];
  // sel, config addr, config data, status, extra addr, extra value
  logic [47:0] t[8] = '{48'h00f3_0801_0000, 48'h01ec_0402_0000, 48'h0200_0004_f440,
    48'h04a1_0210_0000, 48'h06ff_0120_8800, 48'h07ff_0c40_8800, 48'h08f4_0380_f4c3,
    48'h0900_0000_0000};
  int num_errors = 0;
  int checked = 0;

  swel_src u_swel_src (.clk_in(clk_in), .go_in(go), .sel_in(sel), .ev_out(ev),
    .pin_a_out(pin_a), .pin_b_out(pin_b), .rx_out(rx), .rst_n_out(rst_n));
  swel_top u_swel_top (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .temp_delta_in(ev[0]), .supply_delta_in(ev[1]), .supply_restored_event_in(ev[2]),
    .midnight_in(ev[3]), .alarm_in(ev[4]), .battery_switch_in(ev[5]),
    .ext_irq_a_pin_in(pin_a), .ext_irq_b_pin_in(pin_b), .rx_line_in(rx),
    .ext_reset_n_in(rst_n), .core_io_oe_in, .io_oe_out, .pullup_en_out, .lcd_on_out,
    .core_run_out, .core_restart_out, .sleep_state_out, .power_mgmt_irq_out, .irq_out);

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    q.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd

  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) rd_seen <= rd_in;
  always @(negedge clk_in) begin
    if (rd_seen) cmp("rdata_out", {16'h0000, q.pop_front()}, {16'h0000, rdata_out});
  end

  task automatic fire(input logic [3:0] s);
    @(posedge clk_in);
    sel <= s;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
  endtask : fire

  // bounded wait: a wake that never comes must not hang the run
  task automatic await(input logic e);
    repeat (12) if (core_run_out !== 1'b1) @(negedge clk_in);
    cmp("core_run_out", {23'h0, e}, {23'h0, core_run_out});
  endtask : await

  task automatic nap(input logic [3:0] s, input logic e, input logic l);
    wr(ADDR_POWER_CTRL, 8'h10);
    @(negedge clk_in);
    cmp("sleep_state_out", 24'h1, {23'h0, sleep_state_out});
    cmp("io_oe_out", 24'h0, io_oe_out);
    cmp("lcd_on_out", {23'h0, l}, {23'h0, lcd_on_out});
    fire(s);
    await(e);
    if (!e) begin
      fire(4'h9);
      await(1'b1);
    end
  endtask : nap

  task automatic conclude();
    if (q.size() != 0) num_errors++;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    #100000;
    num_errors++;
    conclude();
  end

  initial begin
    logic [7:0] v[7];
    logic [47:0] r;
    logic [3:0] ns[3];
    ns = '{4'h1, 4'h0, 4'h4};
    void'($urandom(32'h1da81961));
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    core_io_oe_in <= 24'($urandom());
    for (int i = 0; i < PORT_NUM; i++) rd(ADDR_PORT0_PULLUP + 8'(i), PULLUP_RESET);
    rd(ADDR_WAKE_STATUS, REG_RESET);
    rd(8'h00, 8'h00);
    rd(ADDR_POWER_CTRL, 8'h00);
    @(negedge clk_in);
    cmp("io_oe_out", core_io_oe_in, io_oe_out);
    $display("test reset_values done");
    // retained state across a midnight wake
    for (int i = 0; i < 7; i++) v[i] = 8'($urandom());
    wr(ADDR_WAKE_MASK, 8'hff);
    wr(ADDR_LCD_PTR, 8'h05);
    wr(ADDR_LCD_DATA, v[0]);
    for (int i = 0; i < 4; i++) wr(ADDR_SCRATCH_BASE + 8'(i), v[i+1]);
    for (int i = 0; i < 3; i++) wr(ADDR_PORT0_PULLUP + 8'(i), v[i+4]);
    wr(ADDR_PERIPHERAL_CONFIGURATION_CONFIG, 8'h20);
    nap(4'h3, 1'b1, 1'b1);
    cmp("pullup_en_out", {v[6], v[5], v[4]}, pullup_en_out);
    cmp("irq_out", 24'h1, {23'h0, irq_out});
    rd(ADDR_LCD_DATA, v[0]);
    for (int i = 0; i < 4; i++) rd(ADDR_SCRATCH_BASE + 8'(i), v[i+1]);
    rd(ADDR_WAKE_STATUS, 8'h08);
    wr(ADDR_WAKE_MASK, 8'h00);
    @(negedge clk_in);
    cmp("irq_out", 24'h0, {23'h0, irq_out});
    wr(ADDR_WAKE_MASK, 8'hff);
    wr(ADDR_WAKE_STATUS, 8'h08);
    wr(ADDR_PERIPHERAL_CONFIGURATION_CONFIG, 8'h00);
    @(negedge clk_in);
    cmp("irq_out", 24'h0, {23'h0, irq_out});
    $display("test retention done");
    // every enabled wake source but midnight, one at a time
    foreach (t[i]) begin
      r = t[i];
      wr(r[39:32], r[31:24]);
      nap(r[43:40], 1'b1, 1'b0);
      cmp("power_mgmt_irq_out", {23'h0, |r[18:17]}, {23'h0, power_mgmt_irq_out});
      rd(ADDR_WAKE_STATUS, r[23:16]);
      rd(r[15:8], r[7:0]);
      wr(r[39:32], 8'h00);
      wr(ADDR_WAKE_STATUS, r[23:16]);
    end
    fire(4'h5);
    rd(ADDR_PERIPHERAL_CONFIGURATION_CONFIG, 8'h80);
    wr(ADDR_PERIPHERAL_CONFIGURATION_CONFIG, 8'h80);
    rd(ADDR_PERIPHERAL_CONFIGURATION_CONFIG, 8'h00);
    // awake falling edges only set the standard pending bits
    wr(ADDR_EXT_TIMER_CTRL, 8'h05);
    fire(4'h6);
    rd(ADDR_EXT_TIMER_CTRL, 8'h07);
    fire(4'h7);
    rd(ADDR_EXT_TIMER_CTRL, 8'h0f);
    rd(ADDR_WAKE_STATUS, 8'h00);
    wr(ADDR_EXT_TIMER_CTRL, 8'h00);
    $display("test wake_sources done");
    // disabled sources must leave the core asleep
    for (int i = 0; i < 3; i++) begin
      nap(ns[i], 1'b0, 1'b0);
      cmp("power_mgmt_irq_out", 24'h0, {23'h0, power_mgmt_irq_out});
      rd(ADDR_WAKE_STATUS, (i == 0) ? 8'h02 : 8'h00);
      wr(ADDR_WAKE_STATUS, 8'hff);
    end
    $display("test masked_sources done");
    repeat (4) @(posedge clk_in);
    conclude();
  end
endmodule : tb
